// ### hw/cia_top.sv
// Card interrupt aggregator: source gating, status, event layer, INTA pin
//
// Functional notes
// - Pin zero drives interrupt only when enabled
// - Pin one drives interrupt only when enabled
// - Pin internal signal is level, optionally inverted
// - Validated power-down sets sticky status bit
// - Reading power-down status clears it
// - Power-down interrupt only when its enable set
// - UART status bit is inverse UART_IRQ_SOURCE_REG bit zero
// - UART interrupt passes only when enabled
// - UART wake enable gates power-management events
// - UART inactivity raises power-down request when enabled
// - One level-sensitive shared interrupt output
// - Interrupt pin field fixed, EEPROM load only
// - Pin field zero keeps interrupt deasserted
// - Interrupt holds until enable or source cleared
// - Event registers bypassed by default
// - Control bit 23 selects event register gating
// - Event mode: mask and latched event needed
// - Event mode: mask clear or write-one drops
// - Present-state shows unlatched combined request
// - Force write makes software interrupt event
// - Event registers decoded in dedicated window
// - Per-source enables still apply in event mode
// - UART enable resets one, EEPROM may override
// - Pin config: input, inverted, drive 0, drive 1
// - Filter time 000 off, 1XX immediate
`timescale 1ns/10ps
`default_nettype none
module cia_top (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic [1:0]  mio_i,
    output logic      [1:0]  mio_o,
    output logic      [1:0]  mio_oe,
    input  wire logic        loc_sel,
    input  wire logic        cb_sel,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    input  wire logic        ee_wr,
    input  wire logic [3:0]  ee_addr,
    input  wire logic [31:0] ee_wdata,
    input  wire logic        ee_int_pin_wr,
    input  wire logic [5:0]  uart_isr,
    input  wire logic [7:0]  uart_rfl,
    input  wire logic [7:0]  uart_tfl,
    input  wire logic        uart_good,
    input  wire logic        uart_idle,
    input  wire logic        uart_wake,
    input  wire logic        pd_valid_in,
    output logic             pd_req,
    output logic             pme_req,
    output logic      [7:0]  int_pin,
    output logic             inta_n,
    output logic             inta_oe
);

    // Pin internal signal; output modes never interrupt
    function automatic logic mio_int_f(input logic [1:0] cfg, input logic lvl);
        mio_int_f = cfg[1] ? 1'b0 : (lvl ^ cfg[0]);
    endfunction

    // Masked register update
    function automatic logic [31:0] wmask_f(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [31:0] m);
        wmask_f = (old & ~m) | (wd & m);
    endfunction

    default clocking cb_clk @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    cia_pin_if pin_bus ();

    logic [31:0] lcc_r;
    logic [31:0] mic_r;
    logic [31:0] gis_r;
    logic        pd_st_r;
    logic        cb_evt_r;
    logic        cb_mask_r;
    logic [7:0]  int_pin_r;
    logic [31:0] reg_rdata_r;
    logic [1:0]  mio_o_r;
    logic [1:0]  mio_oe_r;
    logic        pd_req_r;
    logic        pme_req_r;
    logic        inta_n_r;
    logic        inta_oe_r;
    logic [1:0]  mio_int;
    logic [1:0]  mio_cfg [2];
    logic        uart_irq;
    logic        src_any;
    logic        cb_en;
    logic        irq_req;
    logic [2:0]  filt;
    logic        pd_valid;
    logic        loc_wr;
    logic        loc_rd;
    logic        cb_wr;
    logic        gis_rd;
    logic [31:0] rd_mux;

    // Pin synchroniser
    cia_pin_sync u_sync (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .ce      (ce),
        .pin_i   (mio_i),
        .pins    (pin_bus.src)
    );

    // Decode of bus strobes and derived source states
    assign loc_wr   = loc_sel && reg_wr;
    assign loc_rd   = loc_sel && reg_rd;
    assign cb_wr    = cb_sel && reg_wr;
    assign gis_rd   = loc_rd && (reg_addr == cia_pkg::OFS_GIS);
    assign cb_en    = lcc_r[cia_pkg::LCC_CB_EN];
    assign filt     = lcc_r[cia_pkg::LCC_FILT_HI:cia_pkg::LCC_FILT_LO];
    assign uart_irq = ~uart_isr[0];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_mio
            assign mio_cfg[g] = mic_r[g*cia_pkg::MIC_CFG_W +: cia_pkg::MIC_CFG_W];
            assign mio_int[g] = mio_int_f(mio_cfg[g], pin_bus.level[g]);
        end
    endgenerate

    // Validation: off never validates, 1XX validates immediately
    assign pd_valid = (filt == cia_pkg::FILT_OFF) ? 1'b0 :
                      filt[2] ? pd_req_r : pd_valid_in;

    // Combined gated request from all enabled sources
    assign src_any =
        (mio_int[0] && gis_r[cia_pkg::GIS_MIO_EN_LSB]) ||
        (mio_int[1] && gis_r[cia_pkg::GIS_MIO_EN_LSB + 1]) ||
        (pd_st_r && gis_r[cia_pkg::GIS_PD_EN]) ||
        (uart_irq && gis_r[cia_pkg::GIS_UART_EN]);

    // Output selection: bypass or event layer, killed by pin field zero
    always_comb begin
        if (int_pin_r == cia_pkg::INT_PIN_NONE) begin
            irq_req = 1'b0;
        end else if (cb_en) begin
            irq_req = cb_evt_r && cb_mask_r;
        end else begin
            irq_req = src_any;
        end
    end

    // Local control register
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            lcc_r <= cia_pkg::LCC_RST;
        end else if (ce) begin
            if (ee_wr && (ee_addr == cia_pkg::OFS_LCC)) begin
                lcc_r <= wmask_f(lcc_r, ee_wdata, cia_pkg::LCC_EE_WMASK);
            end else if (loc_wr && (reg_addr == cia_pkg::OFS_LCC)) begin
                lcc_r <= wmask_f(lcc_r, reg_wdata, cia_pkg::LCC_BUS_WMASK);
            end
        end
    end

    // Pin configuration register
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            mic_r <= cia_pkg::MIC_RST;
        end else if (ce) begin
            if (ee_wr && (ee_addr == cia_pkg::OFS_MIC)) begin
                mic_r <= wmask_f(mic_r, ee_wdata, cia_pkg::MIC_WMASK);
            end else if (loc_wr && (reg_addr == cia_pkg::OFS_MIC)) begin
                mic_r <= wmask_f(mic_r, reg_wdata, cia_pkg::MIC_WMASK);
            end
        end
    end

    // Global control bits; the UART enable default may be reloaded
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            gis_r <= cia_pkg::GIS_RST;
        end else if (ce) begin
            if (ee_wr && (ee_addr == cia_pkg::OFS_GIS)) begin
                gis_r <= wmask_f(gis_r, ee_wdata, cia_pkg::GIS_WMASK);
            end else if (loc_wr && (reg_addr == cia_pkg::OFS_GIS)) begin
                gis_r <= wmask_f(gis_r, reg_wdata, cia_pkg::GIS_WMASK);
            end
        end
    end

    // Sticky power-down status; a new validation beats the read clear
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pd_st_r <= 1'b0;
        end else if (ce) begin
            if (pd_valid) begin
                pd_st_r <= 1'b1;
            end else if (gis_rd) begin
                pd_st_r <= 1'b0;
            end
        end
    end

    // Interrupt pin field, written only by the EEPROM loader
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            int_pin_r <= cia_pkg::INT_PIN_RST;
        end else if (ce && ee_int_pin_wr) begin
            int_pin_r <= ee_wdata[7:0];
        end
    end

    // Event latch: set by live request or force, cleared by write-one
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cb_evt_r <= 1'b0;
        end else if (ce) begin
            if (src_any ||
                (cb_wr && (reg_addr == cia_pkg::OFS_CB_FORCE) &&
                 reg_wdata[cia_pkg::CB_INTR])) begin
                cb_evt_r <= 1'b1;
            end else if (cb_wr && (reg_addr == cia_pkg::OFS_CB_EVT) &&
                         reg_wdata[cia_pkg::CB_INTR]) begin
                cb_evt_r <= 1'b0;
            end
        end
    end

    // Event mask, cleared at reset
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cb_mask_r <= 1'b0;
        end else if (ce && cb_wr && (reg_addr == cia_pkg::OFS_CB_MASK)) begin
            cb_mask_r <= reg_wdata[cia_pkg::CB_INTR];
        end
    end

    // Read data multiplexer
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (cb_sel) begin
            unique case (reg_addr)
                cia_pkg::OFS_CB_EVT:   rd_mux[cia_pkg::CB_INTR] = cb_evt_r;
                cia_pkg::OFS_CB_MASK:  rd_mux[cia_pkg::CB_INTR] = cb_mask_r;
                cia_pkg::OFS_CB_PRES:  rd_mux[cia_pkg::CB_INTR] = src_any;
                default:               rd_mux = 32'h0000_0000;
            endcase
        end else begin
            unique case (reg_addr)
                cia_pkg::OFS_LCC: rd_mux = lcc_r;
                cia_pkg::OFS_MIC: rd_mux = mic_r;
                cia_pkg::OFS_UMR: begin
                    rd_mux[7:0] = uart_rfl;
                    rd_mux[cia_pkg::UMR_TFL_LSB +: 8] = uart_tfl;
                    rd_mux[cia_pkg::UMR_ISR_LSB +: 6] = uart_isr;
                    rd_mux[cia_pkg::UMR_GOOD] = uart_good;
                end
                cia_pkg::OFS_GIS: begin
                    rd_mux = gis_r;
                    rd_mux[cia_pkg::GIS_MIO_ST_LSB +: 2] = mio_int;
                    rd_mux[cia_pkg::GIS_PD_ST] = pd_st_r;
                    rd_mux[cia_pkg::GIS_UART_ST] = uart_irq;
                end
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // Registered read data, loaded on each read strobe
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            reg_rdata_r <= 32'h0000_0000;
        end else if (ce && (loc_rd || (cb_sel && reg_rd))) begin
            reg_rdata_r <= rd_mux;
        end
    end

    // Pin drivers from configuration
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            mio_o_r  <= 2'h0;
            mio_oe_r <= 2'h0;
        end else if (ce) begin
            mio_o_r  <= {mio_cfg[1][0], mio_cfg[0][0]};
            mio_oe_r <= {mio_cfg[1][1], mio_cfg[0][1]};
        end
    end

    // Power-down request toward the filter; pins request when idle
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pd_req_r <= 1'b0;
        end else if (ce) begin
            pd_req_r <= (filt != cia_pkg::FILT_OFF) && (
                (gis_r[cia_pkg::GIS_UART_PDF] && uart_idle) ||
                (mic_r[cia_pkg::MIC_PDF_LSB] && !mio_cfg[0][1] && !mio_int[0]) ||
                (mic_r[cia_pkg::MIC_PDF_LSB + 1] && !mio_cfg[1][1] && !mio_int[1]));
        end
    end

    // Power-management event request
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pme_req_r <= 1'b0;
        end else if (ce) begin
            pme_req_r <= (gis_r[cia_pkg::GIS_UART_PME] && uart_wake) ||
                         (mic_r[cia_pkg::MIC_PME_LSB] && mio_int[0]) ||
                         (mic_r[cia_pkg::MIC_PME_LSB + 1] && mio_int[1]);
        end
    end

    // Shared open-drain interrupt pin: enable high pulls the line low
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            inta_n_r  <= 1'b1;
            inta_oe_r <= 1'b0;
        end else if (ce) begin
            inta_n_r  <= !irq_req;
            inta_oe_r <= irq_req;
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign mio_o     = mio_o_r;
    assign mio_oe    = mio_oe_r;
    assign pd_req    = pd_req_r;
    assign pme_req   = pme_req_r;
    assign int_pin   = int_pin_r;
    assign inta_n    = inta_n_r;
    assign inta_oe   = inta_oe_r;

    // Checks on source gating, status bits, wake and power-down requests, the pin zero driver and the output pin
    a_pin_none_quiet: assert property (
        (ce && (int_pin_r == cia_pkg::INT_PIN_NONE)) |=> !inta_oe_r)
        else $error("Interrupt driven with pin field zero");
    a_multipurpose_pin_zero_gate: assert property (
        (ce && !cb_en && (int_pin_r != cia_pkg::INT_PIN_NONE) &&
         mio_int[0] && gis_r[cia_pkg::GIS_MIO_EN_LSB]) |=> inta_oe_r)
        else $error("Enabled pin zero did not interrupt");
    a_multipurpose_pin_one_gate: assert property (
        (ce && !cb_en && (int_pin_r != cia_pkg::INT_PIN_NONE) &&
         mio_int[1] && gis_r[cia_pkg::GIS_MIO_EN_LSB + 1]) |=> inta_oe_r)
        else $error("Enabled pin one did not interrupt");
    a_uart_gate: assert property (
        (ce && !cb_en && (int_pin_r != cia_pkg::INT_PIN_NONE) &&
         uart_irq && gis_r[cia_pkg::GIS_UART_EN]) |=> inta_oe_r)
        else $error("Enabled UART did not interrupt");
    a_pd_gate: assert property (
        (ce && !cb_en && (int_pin_r != cia_pkg::INT_PIN_NONE) &&
         pd_st_r && gis_r[cia_pkg::GIS_PD_EN]) |=> inta_oe_r)
        else $error("Enabled power-down did not interrupt");
    a_pd_sticky: assert property (
        (ce && pd_valid) |=> pd_st_r)
        else $error("Validated power-down not recorded");
    a_pd_read_clr: assert property (
        (ce && gis_rd && !pd_valid) |=> !pd_st_r)
        else $error("Status read did not clear power-down");
    a_uart_status: assert property (
        (ce && gis_rd) |=> (reg_rdata_r[cia_pkg::GIS_UART_ST] == !$past(uart_isr[0])))
        else $error("UART status bit not inverse of UART_IRQ_SOURCE_REG bit");
    a_cb_mask_gate: assert property (
        (ce && cb_en && !cb_mask_r) |=> !inta_oe_r)
        else $error("Event mode interrupt without mask");
    a_oe_pair: assert property (
        inta_oe_r == !inta_n_r)
        else $error("Pin level and enable disagree");
    a_uart_pme: assert property (
        (ce && gis_r[cia_pkg::GIS_UART_PME] && uart_wake) |=> pme_req_r)
        else $error("UART wake did not raise event");
    a_uart_pdreq: assert property (
        (ce && gis_r[cia_pkg::GIS_UART_PDF] && uart_idle &&
         (filt != cia_pkg::FILT_OFF)) |=> pd_req_r)
        else $error("UART idle did not request power-down");
    a_mio_drive: assert property (
        (ce && mio_cfg[0][1]) |=> (mio_oe_r[0] && (mio_o_r[0] == $past(mio_cfg[0][0]))))
        else $error("Pin zero output mode not driven");

    c_uart_irq:  cover property (ce && !cb_en && uart_irq ##1 inta_oe_r);
    c_pd_clear:  cover property (pd_st_r ##1 (ce && gis_rd) ##1 !pd_st_r);
    c_cb_event:  cover property (cb_en && cb_mask_r && cb_evt_r ##1 inta_oe_r);
    c_mio_inv:   cover property (mio_cfg[0] == 2'h1 && mio_int[0]);

endmodule
`default_nettype wire

// ### hw/cia_pkg.sv
// Constants shared by the card interrupt aggregator files
package cia_pkg;

    // Local register offsets, byte addresses
    localparam logic [3:0] OFS_LCC = 4'h0;
    localparam logic [3:0] OFS_MIC = 4'h4;
    localparam logic [3:0] OFS_UMR = 4'h8;
    localparam logic [3:0] OFS_GIS = 4'hC;

    // Function event register offsets in the dedicated memory window
    localparam logic [3:0] OFS_CB_EVT   = 4'h0;
    localparam logic [3:0] OFS_CB_MASK  = 4'h4;
    localparam logic [3:0] OFS_CB_PRES  = 4'h8;
    localparam logic [3:0] OFS_CB_FORCE = 4'hC;
    localparam int         CB_INTR      = 15;

    // Local control register fields
    localparam int LCC_FILT_LO = 5;
    localparam int LCC_FILT_HI = 7;
    localparam int LCC_CB_EN   = 23;
    localparam logic [2:0] FILT_OFF = 3'h0;

    // Pin configuration register fields
    localparam int MIC_CFG_W   = 2;
    localparam int MIC_PME_LSB = 4;
    localparam int MIC_PDF_LSB = 6;

    // Mirror register fields
    localparam int UMR_TFL_LSB = 8;
    localparam int UMR_ISR_LSB = 16;
    localparam int UMR_GOOD    = 27;

    // Global status/control register fields
    localparam int GIS_MIO_ST_LSB = 2;
    localparam int GIS_MIO_EN_LSB = 18;
    localparam int GIS_PD_ST      = 20;
    localparam int GIS_PD_EN      = 21;
    localparam int GIS_UART_ST    = 22;
    localparam int GIS_UART_EN    = 23;
    localparam int GIS_UART_PME   = 24;
    localparam int GIS_UART_PDF   = 25;

    // Write masks for bus and serial-EEPROM writes, and reset values
    localparam logic [31:0] LCC_BUS_WMASK = 32'h27C0_00F8;
    localparam logic [31:0] LCC_EE_WMASK  = 32'h00E0_00FB;
    localparam logic [31:0] MIC_WMASK     = 32'h0000_00FF;
    localparam logic [31:0] GIS_WMASK     = 32'h03AC_0000;
    localparam logic [31:0] LCC_RST       = 32'h0000_0000;
    localparam logic [31:0] MIC_RST       = 32'h0000_0000;
    localparam logic [31:0] GIS_RST       = 32'h008C_0000;

    // Interrupt pin field values
    localparam logic [7:0] INT_PIN_NONE = 8'h00;
    localparam logic [7:0] INT_PIN_RST  = 8'h01;

endpackage

// ### hw/cia_pin_if.sv
// Synchronised multipurpose pin levels passed between design modules
`timescale 1ns/10ps
`default_nettype none
interface cia_pin_if;
    logic [1:0] level;
    modport src (output level);
    modport dst (input level);
endinterface
`default_nettype wire

// ### hw/cia_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module cia_pin_sync (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       ce,
    input  wire logic [1:0] pin_i,
    cia_pin_if.src          pins
);
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pin
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic lvl_r;
            // Shift chain; the first stage feeds only the second
            always_ff @(posedge ref_clk) begin
                if (!rstn) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                end else if (ce) begin
                    s1_r <= pin_i[g];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                end
            end
            // Level follows once stages two and three agree
            always_ff @(posedge ref_clk) begin
                if (!rstn) begin
                    lvl_r <= 1'b0;
                end else if (ce && (s2_r == s3_r)) begin
                    lvl_r <= s3_r;
                end
            end
            assign pins.level[g] = lvl_r;
        end
    endgenerate
endmodule
`default_nettype wire

// ### dv/cia_host_model.sv
// Host side model: pulled-up shared interrupt wire and router view of the pin field
`timescale 1ns/10ps
`default_nettype none
module cia_host_model (
    input  wire logic       ref_clk,
    input  wire logic       inta_n,
    input  wire logic       inta_oe,
    input  wire logic [7:0] int_pin,
    output logic            irq_line,
    output logic            irq_routed
);
    // Open-drain wire with pull-up: low only while the card pulls it
    always_comb begin
        irq_line = (inta_oe && (inta_n == 1'b0)) ? 1'b0 : 1'b1;
    end
    // Router hooks a vector only when the pin field names the single pin
    always_ff @(posedge ref_clk) begin
        irq_routed <= (int_pin == 8'h01);
    end
endmodule
`default_nettype wire

// ### dv/test_card_interrupt_aggregator.sv
// Self-checking bench for the card interrupt aggregator
`timescale 1ns/10ps
`default_nettype none
module test_card_interrupt_aggregator;
    logic        ref_clk, rstn, ce, loc_sel, cb_sel, reg_wr, reg_rd;
    logic        ee_wr, ee_int_pin_wr, uart_good, uart_idle, uart_wake, pd_valid_in;
    logic        pd_req, pme_req, inta_n, inta_oe, irq_line, irq_routed;
    logic [1:0]  mio_i, mio_o, mio_oe;
    logic [3:0]  reg_addr, ee_addr;
    logic [5:0]  uart_isr;
    logic [7:0]  uart_rfl, uart_tfl, int_pin;
    logic [31:0] reg_wdata, reg_rdata, ee_wdata, r, g;
    logic [1:0]  ms;
    int          n_errors, compares;
    integer      seed;

    cia_top cia_top_i (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .mio_i(mio_i), .mio_o(mio_o),
        .mio_oe(mio_oe), .loc_sel(loc_sel), .cb_sel(cb_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ee_wr(ee_wr),
        .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_int_pin_wr(ee_int_pin_wr),
        .uart_isr(uart_isr), .uart_rfl(uart_rfl), .uart_tfl(uart_tfl), .uart_good(uart_good),
        .uart_idle(uart_idle), .uart_wake(uart_wake), .pd_valid_in(pd_valid_in),
        .pd_req(pd_req), .pme_req(pme_req), .int_pin(int_pin), .inta_n(inta_n),
        .inta_oe(inta_oe));
    cia_host_model cia_host_model_i (.ref_clk(ref_clk), .inta_n(inta_n), .inta_oe(inta_oe),
        .int_pin(int_pin), .irq_line(irq_line), .irq_routed(irq_routed));

    // Bus clock, 50 ns period
    always #25 ref_clk = ~ref_clk;

    // Word compare
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Interrupt pin compare, both design pins and the host wire
    task automatic chk_irq(input logic exp);
        compares++;
        if ({inta_n, inta_oe, irq_line} !== {~exp, exp, ~exp}) begin
            n_errors++;
            $display("MISMATCH inta expected %b seen %b", exp, inta_oe);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // One register access, strobes held for exactly one rising edge
    task automatic acc(input logic cb, input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(negedge ref_clk);
        loc_sel = ~cb;
        cb_sel = cb;
        reg_wr = wr;
        reg_rd = ~wr;
        reg_addr = a;
        reg_wdata = d;
        @(negedge ref_clk);
        {loc_sel, cb_sel, reg_wr, reg_rd} = 4'h0;
    endtask
    task automatic wr(input logic cb, input logic [3:0] a, input logic [31:0] d);
        acc(cb, 1'b1, a, d);
    endtask
    task automatic rd(input logic cb, input logic [3:0] a, input string n, input logic [31:0] e);
        acc(cb, 1'b0, a, 32'h0);
        chk(n, e, reg_rdata);
    endtask
    // EEPROM loader pulse: pin field or a local register
    task automatic ee(input logic pin, input logic [3:0] a, input logic [31:0] d);
        @(negedge ref_clk);
        ee_int_pin_wr = pin;
        ee_wr = ~pin;
        ee_addr = a;
        ee_wdata = d;
        @(negedge ref_clk);
        {ee_int_pin_wr, ee_wr} = 2'h0;
    endtask
    // Expected interrupt from enables, UART source and pin internal states
    function automatic logic exp_irq(input logic [31:0] gv, input logic i0, input logic [1:0] m);
        return (gv[18] & m[0]) | (gv[19] & m[1]) | (gv[23] & ~i0);
    endfunction
    task automatic wrap_up;
        $display("Counts: %0d compares, %0d mismatches", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog, well beyond the fewer than one thousand cycles the tests need
    initial begin
        #(50 * 40000);
        n_errors++;
        wrap_up();
    end

    initial begin
        seed = 32'h0ab0;
        {ref_clk, rstn, loc_sel, cb_sel, reg_wr, reg_rd, ee_wr, ee_int_pin_wr} = 8'h00;
        {uart_good, uart_idle, uart_wake, pd_valid_in, mio_i, reg_addr, ee_addr} = 14'h0;
        {reg_wdata, ee_wdata, uart_rfl, uart_tfl} = 80'h0;
        ce = 1'b1;
        uart_isr = 6'h01;
        repeat (16) @(negedge ref_clk);
        rstn = 1'b1;
        wt(1);
        chk_irq(1'b0);
        chk("int_pin", 32'h01, {24'h0, int_pin});
        rd(0, cia_pkg::OFS_GIS, "gis_rst", 32'h008C_0000);
        ee(0, cia_pkg::OFS_GIS, 32'h000C_0000);
        rd(0, cia_pkg::OFS_GIS, "gis_ee", 32'h000C_0000);
        wr(0, cia_pkg::OFS_GIS, 32'h008C_0000);
        $display("test reset done");
        // UART source held, then removed by enable and by source
        ce = 1'b0;
        uart_isr = 6'h04;
        wt(3);
        chk_irq(1'b0);
        ce = 1'b1;
        wt(2);
        chk_irq(1'b1);
        wt(5);
        chk_irq(1'b1);
        rd(0, cia_pkg::OFS_GIS, "gis_uart", 32'h00CC_0000);
        wr(0, cia_pkg::OFS_GIS, 32'h000C_0000);
        wt(2);
        chk_irq(1'b0);
        wr(0, cia_pkg::OFS_GIS, 32'h008C_0000);
        uart_isr = 6'h01;
        wt(3);
        chk_irq(1'b0);
        $display("test uart done");
        // Pin polarity and enables, both pins, both input modes
        for (int p = 0; p < 2; p++) begin
            for (int inv = 0; inv < 2; inv++) begin
                wr(0, cia_pkg::OFS_MIC, 32'(inv << (2 * p)));
                mio_i = 2'(!inv << p);
                wt(6);
                chk_irq(1'b1);
                mio_i = 2'(inv << p);
                wt(6);
                chk_irq(1'b0);
                mio_i = 2'(!inv << p);
                wr(0, cia_pkg::OFS_GIS, 32'h008C_0000 & ~(32'h1 << (18 + p)));
                wt(6);
                chk_irq(1'b0);
                wr(0, cia_pkg::OFS_GIS, 32'h008C_0000);
            end
        end
        // Output modes: pin 0 drives one, pin 1 drives zero, no interrupt
        mio_i = 2'h3;
        wr(0, cia_pkg::OFS_MIC, 32'h0000_000B);
        wt(6);
        chk("mio_drive", 32'hD, {28'h0, mio_oe, mio_o});
        chk_irq(1'b0);
        wr(0, cia_pkg::OFS_MIC, 32'h0);
        mio_i = 2'h0;
        $display("test pins done");
        // Power-down: immediate filter, sticky status, read clear, enable
        wr(0, cia_pkg::OFS_LCC, 32'h0000_0080);
        wr(0, cia_pkg::OFS_GIS, 32'h028C_0000);
        uart_idle = 1'b1;
        wt(3);
        chk("pd_req", 32'h1, {31'h0, pd_req});
        chk_irq(1'b0);
        uart_idle = 1'b0;
        wt(3);
        rd(0, cia_pkg::OFS_GIS, "gis_pd", 32'h029C_0000);
        rd(0, cia_pkg::OFS_GIS, "gis_pdclr", 32'h028C_0000);
        uart_idle = 1'b1;
        wr(0, cia_pkg::OFS_GIS, 32'h02AC_0000);
        wt(3);
        chk_irq(1'b1);
        uart_idle = 1'b0;
        wr(0, cia_pkg::OFS_LCC, 32'h0);
        wr(0, cia_pkg::OFS_GIS, 32'h028C_0000);
        rd(0, cia_pkg::OFS_GIS, "gis_pd2", 32'h029C_0000);
        uart_idle = 1'b1;
        wt(3);
        chk("pd_off", 32'h0, {31'h0, pd_req});
        rd(0, cia_pkg::OFS_GIS, "gis_pdoff", 32'h028C_0000);
        uart_idle = 1'b0;
        // Wake events gated by their enable
        wr(0, cia_pkg::OFS_GIS, 32'h018C_0000);
        uart_wake = 1'b1;
        wt(3);
        chk("pme_on", 32'h1, {31'h0, pme_req});
        wr(0, cia_pkg::OFS_GIS, 32'h008C_0000);
        wt(3);
        chk("pme_off", 32'h0, {31'h0, pme_req});
        uart_wake = 1'b0;
        $display("test power done");
        // Pin field zero silences the UART source
        ee(1, 4'h0, 32'h0);
        uart_isr = 6'h04;
        wt(3);
        chk("pin_none", 32'h0, {23'h0, irq_routed, int_pin});
        chk_irq(1'b0);
        ee(1, 4'h0, 32'h1);
        wt(2);
        chk_irq(1'b1);
        chk("routed", 32'h1, {31'h0, irq_routed});
        // Event register layer: mask, latch, clear, force, source enables
        wr(0, cia_pkg::OFS_LCC, 32'h0080_0000);
        wt(2);
        chk_irq(1'b0);
        rd(1, cia_pkg::OFS_CB_PRES, "present", 32'h8000);
        wr(1, cia_pkg::OFS_CB_MASK, 32'h8000);
        wt(2);
        chk_irq(1'b1);
        uart_isr = 6'h01;
        wt(3);
        chk_irq(1'b1);
        rd(1, cia_pkg::OFS_CB_PRES, "present_off", 32'h0);
        wr(1, cia_pkg::OFS_CB_EVT, 32'h8000);
        wt(2);
        chk_irq(1'b0);
        wr(1, cia_pkg::OFS_CB_FORCE, 32'h8000);
        wt(2);
        chk_irq(1'b1);
        wr(1, cia_pkg::OFS_CB_MASK, 32'h0);
        wt(2);
        chk_irq(1'b0);
        wr(0, cia_pkg::OFS_GIS, 32'h000C_0000);
        uart_isr = 6'h04;
        wt(3);
        rd(1, cia_pkg::OFS_CB_PRES, "present_dis", 32'h0);
        uart_isr = 6'h01;
        wr(0, cia_pkg::OFS_LCC, 32'h0);
        $display("test events done");
        // Random enables, polarities, pin levels and UART mirror
        for (int k = 0; k < 40; k++) begin
            r = $random(seed);
            g = $random(seed) & 32'h018C_0000;
            {uart_good, uart_tfl, uart_rfl, uart_isr, mio_i} = r[30:6];
            ms = r[7:6] ^ {r[3], r[2]};
            wr(0, cia_pkg::OFS_MIC, {28'h0, 1'b0, r[3], 1'b0, r[2]});
            wr(0, cia_pkg::OFS_GIS, g);
            wt(6);
            chk_irq(exp_irq(g, r[8], ms));
            rd(0, cia_pkg::OFS_GIS, "gis_rnd", g | {9'h0, ~r[8], 18'h0, ms, 2'h0});
            rd(0, cia_pkg::OFS_UMR, "umr_rnd", {4'h0, r[30], 5'h0, r[13:8], r[29:22], r[21:14]});
        end
        $display("test random done");
        wrap_up();
    end
endmodule
`default_nettype wire
